/* File: bench/dic_field_model.sv */
`timescale 1ns/1ns
module dic_field_model (
    input  wire logic       clk_sys,
    input  wire logic [2:0] energize,
    output logic [2:0]      field_level
);
    // field voltage follows the requested switch state one clock later
    initial field_level = 3'h0;
    always @(posedge clk_sys) begin
        field_level <= energize;
    end
endmodule

/* File: bench/dic_tb_top.sv */
`timescale 1ns/1ns
module dic_tb_top;
    import dic_pkg::*;
    logic                    clk_sys = 1'b0;
    logic                    rst_b = 1'b0;
    logic [2:0]              energize = 3'h0;
    logic [2:0]              field_level;
    logic [2:0]              polarity_nc = 3'h0;
    logic [2:0]              ac_mode = 3'h0;
    logic [2:0][DELAY_W-1:0] act_delay_ms = '0;
    logic [2:0][DELAY_W-1:0] drop_delay_ms = '0;
    logic [4:0]              relay_cmd = 5'h00;
    logic [4:0]              direct_en = 5'h00;
    logic [4:0][SRC_W-1:0]   direct_src = '0;
    logic                    sys_fault = 1'b0;
    logic                    power_good = 1'b0;
    logic [2:0]              cond_status;
    logic [2:0]              logic_status;
    logic [4:0]              relay_output_n;
    logic                    fault_contact_healthy;
    logic                    scan_strobe;
    int                      mismatches = 0;
    int                      cmp_count = 0;
    int                      cycles = 0;

    // 100 ns clock and a cycle ceiling against hangs
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end

    dic_field_model field (.clk_sys(clk_sys), .energize(energize), .field_level(field_level));

    // scan is 5 steps of 4 cycles, i.e. 20 cycles
    dic_top #(.STEP_CYC(4)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .digital_input_n(field_level),
        .polarity_nc(polarity_nc), .act_delay_ms(act_delay_ms),
        .drop_delay_ms(drop_delay_ms), .ac_mode(ac_mode), .relay_cmd(relay_cmd),
        .direct_en(direct_en), .direct_src(direct_src), .sys_fault(sys_fault),
        .power_good(power_good), .cond_status(cond_status), .logic_status(logic_status),
        .relay_output_n(relay_output_n), .fault_contact_healthy(fault_contact_healthy),
        .scan_strobe(scan_strobe));

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // wait for n scan strobes, returning just after the edge that shows new values
    task automatic scans(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge clk_sys);
                #1;
                k++;
            end while (scan_strobe !== 1'b1 && k < 40);
            if (k >= 40) check("scan_strobe", 8'h01, 8'h00);
        end
    endtask

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        logic [1:0] pf;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        check("fault_contact_rst", 8'h00, {7'h0, fault_contact_healthy});
        check("relay_rst", 8'h00, {3'h0, relay_output_n});
        // every power and fault combination, healthy only when powered and fault-free
        for (int i = 0; i < 4; i++) begin
            pf = i[1:0];
            @(posedge clk_sys);
            {power_good, sys_fault} <= pf;
            @(posedge clk_sys);
            #1;
            check("fault_contact", {7'h0, pf == 2'b10}, {7'h0, fault_contact_healthy});
        end
        @(posedge clk_sys);
        power_good <= 1'b1;
        sys_fault <= 1'b0;
        act_delay_ms[2] <= 21'd12;
        direct_en <= 5'h01;
        scans(1);
        // input 0 energized, input 1 normally closed and idle
        @(posedge clk_sys);
        energize <= 3'h1;
        polarity_nc <= 3'h2;
        relay_cmd <= 5'h10;
        scans(1);
        check("cond_first", 8'h03, {5'h0, cond_status});
        check("logic_first", 8'h00, {5'h0, logic_status});
        check("relay_first", 8'h10, {3'h0, relay_output_n});
        scans(1);
        check("logic_second", 8'h03, {5'h0, logic_status});
        check("relay_second", 8'h10, {3'h0, relay_output_n});
        scans(1);
        check("relay_third", 8'h11, {3'h0, relay_output_n});
        // short pulse on input 2 cancels its pick-up timer, then a full one
        @(posedge clk_sys);
        energize <= 3'h5;
        scans(1);
        @(posedge clk_sys);
        energize <= 3'h1;
        scans(3);
        check("cond_cancel", 8'h03, {5'h0, cond_status});
        @(posedge clk_sys);
        energize <= 3'h5;
        scans(3);
        check("cond_act_wait", 8'h03, {5'h0, cond_status});
        scans(1);
        check("cond_act_done", 8'h07, {5'h0, cond_status});
        // drop 7 ms on input 0, ac mode with zero drop on input 1
        @(posedge clk_sys);
        drop_delay_ms[0] <= 21'd7;
        ac_mode <= 3'h2;
        energize <= 3'h6;
        scans(2);
        check("cond_drop_wait", 8'h07, {5'h0, cond_status});
        scans(1);
        check("cond_drop_done", 8'h06, {5'h0, cond_status});
        scans(3);
        check("cond_ac_wait", 8'h06, {5'h0, cond_status});
        scans(1);
        check("cond_ac_done", 8'h04, {5'h0, cond_status});
        finish_test();
    end
endmodule

/* File: hw/dic_tick_gen.sv */
`timescale 1ns/1ns
module dic_tick_gen #(
    parameter int unsigned STEP_CYC = dic_pkg::STEP_CYCLES
) (
    input  wire logic  clk_sys,
    input  wire logic  rst_b,
    dic_tick_if.source tk
);
    import dic_pkg::*;

    typedef struct packed {
        logic [STEP_CNT_W-1:0] step_cnt;
        logic [SCAN_CNT_W-1:0] scan_cnt;
        logic                  ms_tick;
        logic                  scan_tick;
    } dic_tick_st_t;

    localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(STEP_CYC - 1);
    localparam logic [SCAN_CNT_W-1:0] SCAN_LAST = SCAN_CNT_W'(SCAN_PERIOD_MS - 1);

    // refuse step lengths the counter cannot hold
    if (STEP_CYC < 1 || STEP_CYC >= (1 << STEP_CNT_W)) begin : g_bad_step
        $error("dic_tick_gen: STEP_CYC out of range");
    end

    dic_tick_st_t st;
    dic_tick_st_t next_st;

    // one ms step pulse, every fifth step also a scan pulse
    always_comb begin
        next_st           = st;
        next_st.ms_tick   = 1'b0;
        next_st.scan_tick = 1'b0;
        if (st.step_cnt == STEP_LAST) begin
            next_st.step_cnt = '0;
            next_st.ms_tick  = 1'b1;
            if (st.scan_cnt == SCAN_LAST) begin
                next_st.scan_cnt  = '0;
                next_st.scan_tick = 1'b1;
            end else begin
                next_st.scan_cnt = st.scan_cnt + SCAN_CNT_W'(1);
            end
        end else begin
            next_st.step_cnt = st.step_cnt + STEP_CNT_W'(1);
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tk.ms_tick   = st.ms_tick;
    assign tk.scan_tick = st.scan_tick;
endmodule

/* File: hw/dic_top.sv */
`timescale 1ns/1ns
// What this block does
// - every input is sampled once per 5 ms scan into internal state
// - relay output commands are refreshed once per 5 ms scan
// - per-input polarity: energized reads 1 when normally open, 0 when closed
// - activation delay in 1 ms steps postpones each 0 to 1 change
// - drop-off delay in 1 ms steps postpones each 1 to 0 change
// - AC mode adds 30 ms to the drop-off delay, off by default
// - fault contact healthy only when powered and fault-free, else fault position
// - status seen by internal functions follows one further scan later
// - input routed to a relay reaches it one more scan after that
module dic_top #(
    parameter int unsigned N_IN     = dic_pkg::NUM_INPUTS,
    parameter int unsigned N_OUT    = dic_pkg::NUM_RELAYS,
    parameter int unsigned STEP_CYC = dic_pkg::STEP_CYCLES
) (
    input  wire logic                                   clk_sys,
    input  wire logic                                   rst_b,
    input  wire logic [N_IN-1:0]                        digital_input_n,
    input  wire logic [N_IN-1:0]                        polarity_nc,
    input  wire logic [N_IN-1:0][dic_pkg::DELAY_W-1:0]  act_delay_ms,
    input  wire logic [N_IN-1:0][dic_pkg::DELAY_W-1:0]  drop_delay_ms,
    input  wire logic [N_IN-1:0]                        ac_mode,
    input  wire logic [N_OUT-1:0]                       relay_cmd,
    input  wire logic [N_OUT-1:0]                       direct_en,
    input  wire logic [N_OUT-1:0][dic_pkg::SRC_W-1:0]   direct_src,
    input  wire logic                                   sys_fault,
    input  wire logic                                   power_good,
    output logic [N_IN-1:0]                             cond_status,
    output logic [N_IN-1:0]                             logic_status,
    output logic [N_OUT-1:0]                            relay_output_n,
    output logic                                        fault_contact_healthy,
    output logic                                        scan_strobe
);
    import dic_pkg::*;

    // refuse sizes the selectors cannot serve
    if (N_IN < 1 || N_IN > (1 << SRC_W) || N_OUT < 1) begin : g_bad_size
        $error("dic_top: N_IN or N_OUT out of range");
    end

    // refuse a delay width that cannot hold the longest delay plus the ac extra
    if (DELAY_MAX_MS + AC_EXTRA_MS >= (1 << DELAY_W)) begin : g_bad_delay
        $error("dic_top: DELAY_W too narrow for the delay range");
    end

    typedef struct packed {
        logic [N_IN-1:0]               samp;
        logic [N_IN-1:0]               cond;
        logic [N_IN-1:0][DELAY_W-1:0]  elapsed;
        logic [N_IN-1:0]               to_logic;
        logic [N_OUT-1:0]              relay;
        logic                          healthy;
        logic                          scan_seen;
    } dic_state_t;

    dic_state_t st;
    dic_state_t next_st;

    dic_tick_if tk ();

    dic_tick_gen #(
        .STEP_CYC (STEP_CYC)
    ) u_tick (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .tk      (tk)
    );

    logic [N_IN-1:0]              lvl;
    logic [N_IN-1:0][DELAY_W:0]   need;
    logic [N_OUT-1:0]             relay_val;

    // per-input level after polarity and delay required for the pending edge
    for (genvar i = 0; i < N_IN; i++) begin : g_in
        assign lvl[i]  = digital_input_n[i] ^ polarity_nc[i];
        assign need[i] = lvl[i] ? {1'b0, act_delay_ms[i]}
                       : ({1'b0, drop_delay_ms[i]} + (ac_mode[i] ? AC_EXTRA : '0));
    end

    // per-relay command source: routed input status or internal logic
    for (genvar k = 0; k < N_OUT; k++) begin : g_out
        assign relay_val[k] = direct_en[k] ? st.to_logic[direct_src[k]] : relay_cmd[k];
    end

    // scan-driven conditioning, logic view and relay refresh
    always_comb begin
        next_st           = st;
        next_st.scan_seen = tk.scan_tick;
        next_st.healthy   = power_good & ~sys_fault;
        for (int i = 0; i < N_IN; i++) begin
            if (tk.scan_tick) begin
                next_st.samp[i] = lvl[i];
                if (lvl[i] == st.cond[i]) begin
                    next_st.elapsed[i] = DELAY_RST;
                end else if ({1'b0, st.elapsed[i]} >= need[i]) begin
                    next_st.cond[i]    = lvl[i];
                    next_st.elapsed[i] = DELAY_RST;
                end else if (tk.ms_tick && st.elapsed[i] != ELAPSED_MAX) begin
                    next_st.elapsed[i] = st.elapsed[i] + DELAY_W'(1);
                end
            end else if (tk.ms_tick && st.samp[i] != st.cond[i]
                         && st.elapsed[i] != ELAPSED_MAX) begin
                next_st.elapsed[i] = st.elapsed[i] + DELAY_W'(1); // step count while pending
            end
        end
        if (tk.scan_tick) begin
            next_st.to_logic = st.cond;
            next_st.relay    = relay_val;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cond_status           = st.cond;
    assign logic_status          = st.to_logic;
    assign relay_output_n        = st.relay;
    assign fault_contact_healthy = st.healthy;
    assign scan_strobe           = st.scan_seen;

    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // a scan pulse followed by the register update one edge later
    sequence s_scan_step;
        tk.scan_tick ##1 1'b1;
    endsequence

    // samples only move on a scan
    a_sample_on_scan: assert property ($changed(st.samp) |-> $past(tk.scan_tick))
        else $error("input sample changed between scans");

    // relays only move on a scan
    a_relay_on_scan: assert property ($changed(st.relay) |-> $past(tk.scan_tick))
        else $error("relay output changed between scans");

    // sample equals pin level with polarity applied
    a_polarity_map: assert property (tk.scan_tick |=> st.samp == $past(lvl))
        else $error("sample does not match polarity-corrected input");

    // conditioned status only moves on a scan
    a_cond_on_scan: assert property ($changed(st.cond) |-> $past(tk.scan_tick))
        else $error("conditioned status changed between scans");

    // logic view is the previous conditioned status
    a_logic_follow: assert property (s_scan_step |-> st.to_logic == $past(st.cond))
        else $error("logic status did not follow conditioned status");

    // fault position whenever fault or power loss
    a_fault_contact: assert property (!power_good || sys_fault |=> !fault_contact_healthy)
        else $error("fault contact healthy during fault");

    // healthy position when powered and clear
    a_healthy_contact: assert property (power_good && !sys_fault |=> fault_contact_healthy)
        else $error("fault contact not healthy when fault-free");

    // the strobe shows the scan pulse one edge late
    a_scan_strobe: assert property (scan_strobe == $past(tk.scan_tick))
        else $error("scan strobe out of step with the scan pulse");

    // logic view only moves on a scan
    a_logic_on_scan: assert property ($changed(st.to_logic) |-> $past(tk.scan_tick))
        else $error("logic status changed between scans");

    // every scan pulse falls on a step pulse
    a_tick_nest: assert property (tk.scan_tick |-> tk.ms_tick)
        else $error("scan pulse without step pulse");

    // a scan pulse lasts a single cycle
    a_scan_single: assert property (tk.scan_tick |=> !tk.scan_tick)
        else $error("scan pulse lasted more than one cycle");

    for (genvar i = 0; i < N_IN; i++) begin : g_chk
        // rise only after activation delay elapsed
        a_rise_delay: assert property ($rose(st.cond[i])
            |-> $past({1'b0, st.elapsed[i]}) >= $past({1'b0, act_delay_ms[i]}))
            else $error("status rose before activation delay");
        // fall only after drop-off delay elapsed
        a_fall_delay: assert property ($fell(st.cond[i])
            |-> $past({1'b0, st.elapsed[i]}) >= $past({1'b0, drop_delay_ms[i]}))
            else $error("status fell before drop-off delay");
        // ac mode adds the fixed extra drop-off time
        a_ac_extra: assert property ($fell(st.cond[i]) && $past(ac_mode[i])
            |-> $past({1'b0, st.elapsed[i]}) >= AC_EXTRA)
            else $error("status fell before ac extra delay");
        // level returning cancels the timer and keeps the status
        a_cancel_pend: assert property (tk.scan_tick && lvl[i] == st.cond[i]
            |=> st.elapsed[i] == DELAY_RST && $stable(st.cond[i]))
            else $error("pending delay not cancelled");
        // an expired delay hands the sampled level over at that scan
        a_cond_settle: assert property (tk.scan_tick && lvl[i] != st.cond[i]
            && {1'b0, st.elapsed[i]} >= need[i] |=> st.cond[i] == $past(lvl[i]))
            else $error("conditioned status not updated after delay");
        // the step count stands still while nothing is pending
        a_elapsed_idle: assert property (!tk.scan_tick && st.samp[i] == st.cond[i]
            |=> $stable(st.elapsed[i]))
            else $error("delay count moved with no pending change");
        // a saturated step count holds until it is cleared
        a_elapsed_sat: assert property (st.elapsed[i] == ELAPSED_MAX
            |=> st.elapsed[i] == ELAPSED_MAX || st.elapsed[i] == DELAY_RST)
            else $error("saturated delay count wrapped");
    end

    for (genvar k = 0; k < N_OUT; k++) begin : g_rchk
        // routed relay takes logic view at the next scan
        a_direct_route: assert property (tk.scan_tick && direct_en[k]
            |=> st.relay[k] == $past(st.to_logic[direct_src[k]]))
            else $error("routed relay did not follow input");
        // a relay not routed takes the logic command at the scan
        a_relay_cmd: assert property (tk.scan_tick && !direct_en[k]
            |=> st.relay[k] == $past(relay_cmd[k]))
            else $error("relay did not take its command");
    end
endmodule

/* File: inc/dic_pkg.sv */
package dic_pkg;
    // clock and time base
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned MS_PER_S        = 1000;
    localparam int unsigned STEP_MS         = 1;
    localparam int unsigned STEP_CYCLES     = STEP_MS * (CLK_HZ / MS_PER_S);
    localparam int unsigned SCAN_PERIOD_MS  = 5;
    localparam int unsigned STEP_CNT_W      = 14;
    localparam int unsigned SCAN_CNT_W      = 3;
    // input conditioning
    localparam int unsigned NUM_INPUTS      = 3;
    localparam int unsigned NUM_RELAYS      = 5;
    localparam int unsigned DELAY_MAX_MS    = 1_800_000;
    localparam int unsigned DELAY_W         = 21;
    localparam int unsigned AC_EXTRA_MS     = 30;
    localparam logic [DELAY_W:0] AC_EXTRA   = (DELAY_W+1)'(AC_EXTRA_MS);
    localparam logic [DELAY_W-1:0] DELAY_RST = '0;
    localparam logic [DELAY_W-1:0] ELAPSED_MAX = '1;
    localparam int unsigned SRC_W           = 2;
    // polarity encoding of a polarity bit
    localparam logic POL_NORMALLY_OPEN      = 1'b0;
    localparam logic POL_NORMALLY_CLOSED    = 1'b1;
endpackage

/* File: inc/dic_tick_if.sv */
`timescale 1ns/1ns
interface dic_tick_if;
    logic ms_tick;
    logic scan_tick;
    modport source (output ms_tick, output scan_tick);
    modport sink   (input  ms_tick, input  scan_tick);
endinterface
